/* File: rtl/usb_irq_pkg.sv */
// usb interrupt gating: register map, field positions, timing counts, carriers
// assumes a 100 MHz core clock and software access over apb
//
// Summary of operation
// R1: status enable bit gates its flag to request
// R2: enables gate propagation only, flags always set
// R3: status enables bits 6..0, bit 7 zero, reset zero
// R4: error summary is OR of enabled error flags
// R5: error enable bit passes or blocks its flag
// R6: error flag sets in detection cycle
// R7: flags stick until software writes zero
// R8: bit 7 stuff error; bits 6,5 read zero
// R9: bit 4 idle over 16 bit times after eop
// R10: bit 3 data field not whole bytes
// R11: bit 2 data crc16 check failure
// R12: bit 1 token crc5 failure, token rejected
// R13: bit 0 packet id check failure
// R14: error enables at 7,4..0, reset zero
// R15: idle over 3 ms sets idle detect flag
// R16: pull-up stays enabled while suspended
// R17: firmware enables module after attach seen
// R18: enabled status flags OR into request
// R19: error summary bit read-only, software cannot write
// R20: hardware set wins over software clear
package usb_irq_pkg;

  localparam logic [11:0] status_flag_off = 12'h000;
  localparam logic [11:0] status_en_off = 12'h004;
  localparam logic [11:0] error_flag_off = 12'h008;
  localparam logic [11:0] error_en_off = 12'h00c;
  localparam logic [11:0] control_off = 12'h010;

  // status flag bit positions
  localparam int bus_reset_bit = 0;
  localparam int error_summary_bit = 1;
  localparam int bus_activity_bit = 2;
  localparam int transaction_done_bit = 3;
  localparam int idle_detect_bit = 4;
  localparam int stall_sent_bit = 5;
  localparam int frame_start_bit = 6;

  // error flag bit positions
  localparam int packet_id_fail_bit = 0;
  localparam int token_check_fail_bit = 1;
  localparam int data_check_fail_bit = 2;
  localparam int partial_byte_bit = 3;
  localparam int turnaround_timeout_bit = 4;
  localparam int stuff_error_bit = 7;

  localparam logic [7:0] status_mask = 8'h7f;
  localparam logic [7:0] status_sw_mask = 8'h7d;
  localparam logic [7:0] error_mask = 8'h9f;
  localparam logic [7:0] reg_reset = 8'h00;

  // control register fields
  localparam int module_en_bit = 0;
  localparam int suspend_bit = 1;
  localparam int pullup_en_bit = 2;

  localparam int core_clk_mhz = 100;
  localparam int idle_time_us = 3000;
  localparam int idle_cycles = idle_time_us * core_clk_mhz;
  localparam int turnaround_bit_times = 16;
  localparam int bit_time_ns = 84;
  localparam int bit_time_cycles = (bit_time_ns * core_clk_mhz) / 1000;

  typedef struct packed {
    logic stuff_error;
    logic turnaround_idle;
    logic partial_byte;
    logic data_check_fail;
    logic token_check_fail;
    logic packet_id_fail;
  } error_event_t;

  typedef struct packed {
    logic frame_start;
    logic stall_sent;
    logic transaction_done;
    logic bus_activity;
    logic bus_reset;
  } status_event_t;

endpackage : usb_irq_pkg

/* File: rtl/line_timer.sv */
// idle timers: bit-time enable divider, turnaround and suspend idle counters
// assumes bus_idle and eop_seen are already synchronised to core_clk
`timescale 1ns/1ns
module line_timer #(
  parameter int idle_cycles = usb_irq_pkg::idle_cycles,
  parameter int bit_cycles = usb_irq_pkg::bit_time_cycles,
  parameter int turn_bits = usb_irq_pkg::turnaround_bit_times
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic bus_idle,
  input wire logic eop_seen,
  output logic turnaround_timeout,
  output logic idle_timeout
);

  initial
  begin
    if (idle_cycles < 2 || bit_cycles < 1 || turn_bits < 1)
      $error("line_timer: counts too small");
  end

  logic [7:0] bit_div;
  logic bit_tick;
  logic [7:0] turn_count;
  logic turn_armed;
  logic [31:0] idle_count;

  // one-cycle enable per bit time
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || bit_div == 8'(bit_cycles - 1))
      bit_div <= 8'h00;
    else
      bit_div <= bit_div + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      bit_tick <= 1'b0;
    else
      bit_tick <= (bit_div == 8'(bit_cycles - 1));
  end

  // turnaround watch arms at eop, pulses once after more than turn_bits idle
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      turn_count <= 8'h00;
      turn_armed <= 1'b0;
      turnaround_timeout <= 1'b0;
    end
    else
    begin
      turnaround_timeout <= 1'b0;
      if (eop_seen)
      begin
        turn_count <= 8'h00;
        turn_armed <= 1'b1;
      end
      else if (!bus_idle)
        turn_armed <= 1'b0;
      else if (turn_armed && bit_tick)
      begin
        if (turn_count == 8'(turn_bits))
        begin
          turnaround_timeout <= 1'b1; // see R9
          turn_armed <= 1'b0;
        end
        else
          turn_count <= turn_count + 8'h01;
      end
    end
  end

  // suspend idle: one pulse per idle stretch
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      idle_count <= 32'h0000_0000;
      idle_timeout <= 1'b0;
    end
    else
    begin
      idle_timeout <= 1'b0;
      if (!bus_idle)
        idle_count <= 32'h0000_0000;
      else if (idle_count < 32'(idle_cycles))
        idle_count <= idle_count + 32'h0000_0001;
      else if (idle_count == 32'(idle_cycles))
      begin
        idle_timeout <= 1'b1; // see R15
        idle_count <= idle_count + 32'h0000_0001;
      end
    end
  end

endmodule : line_timer

/* File: rtl/usb_irq_gate.sv */
// usb status and error flag registers with two-level interrupt gating
// assumes the serial engine gives same-clock event pulses; line levels are async
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
module usb_irq_gate #(
  parameter int idle_cycles = usb_irq_pkg::idle_cycles
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire usb_irq_pkg::status_event_t status_event,
  input wire usb_irq_pkg::error_event_t error_event,
  input wire logic line_idle_pin,
  input wire logic eop_seen,
  output logic usb_request_flag,
  output logic pullup_en,
  output logic module_en,
  output logic suspended
);

  initial
  begin
    if (idle_cycles < 2)
      $error("usb_irq_gate: idle_cycles too small");
  end

  logic [7:0] status_flag_reg;
  logic [7:0] usb_status_irq_enable;
  logic [7:0] usb_error_flags;
  logic [7:0] usb_error_irq_enable;
  logic [2:0] control_reg;
  logic [2:0] idle_sync;
  logic line_idle;
  logic turnaround_timeout;
  logic idle_timeout;
  logic [7:0] error_set;
  logic [7:0] status_set;
  logic error_summary_flag;
  logic access;
  logic wr_en;
  logic [7:0] wbyte;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, usb_irq_pkg::status_flag_off) || hit(addr, usb_irq_pkg::status_en_off)
      || hit(addr, usb_irq_pkg::error_flag_off) || hit(addr, usb_irq_pkg::error_en_off)
      || hit(addr, usb_irq_pkg::control_off);
  endfunction : mapped

  assign access = psel && penable && pready;
  assign wr_en = access && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];

  // pin level, three stages; accepted when the last two agree
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      idle_sync <= 3'b111;
    else
      idle_sync <= {idle_sync[1:0], line_idle_pin};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      line_idle <= 1'b1;
    else if (idle_sync[2] == idle_sync[1])
      line_idle <= idle_sync[2];
  end

  line_timer #(
    .idle_cycles(idle_cycles),
    .bit_cycles(usb_irq_pkg::bit_time_cycles),
    .turn_bits(usb_irq_pkg::turnaround_bit_times)
  ) u_line_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .bus_idle(line_idle),
    .eop_seen(eop_seen),
    .turnaround_timeout(turnaround_timeout),
    .idle_timeout(idle_timeout)
  );

  always_comb
  begin
    error_set = 8'h00;
    error_set[usb_irq_pkg::stuff_error_bit] = error_event.stuff_error; // see R8
    error_set[usb_irq_pkg::turnaround_timeout_bit] =
      error_event.turnaround_idle | turnaround_timeout; // see R9
    error_set[usb_irq_pkg::partial_byte_bit] = error_event.partial_byte; // see R10
    error_set[usb_irq_pkg::data_check_fail_bit] = error_event.data_check_fail; // see R11
    error_set[usb_irq_pkg::token_check_fail_bit] = error_event.token_check_fail; // see R12
    error_set[usb_irq_pkg::packet_id_fail_bit] = error_event.packet_id_fail; // see R13
  end

  always_comb
  begin
    status_set = 8'h00;
    status_set[usb_irq_pkg::frame_start_bit] = status_event.frame_start;
    status_set[usb_irq_pkg::stall_sent_bit] = status_event.stall_sent;
    status_set[usb_irq_pkg::idle_detect_bit] = idle_timeout; // see R15
    status_set[usb_irq_pkg::transaction_done_bit] = status_event.transaction_done;
    status_set[usb_irq_pkg::bus_activity_bit] = status_event.bus_activity;
    status_set[usb_irq_pkg::bus_reset_bit] = status_event.bus_reset;
  end

  // error flags: set in the detection cycle regardless of enables, cleared by writing 0
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      usb_error_flags <= usb_irq_pkg::reg_reset;
    else if (wr_en && hit(paddr, usb_irq_pkg::error_flag_off))
      usb_error_flags <= ((usb_error_flags & wbyte) | error_set)
        & usb_irq_pkg::error_mask; // see R7 R20
    else
      usb_error_flags <= (usb_error_flags | error_set) & usb_irq_pkg::error_mask; // see R2 R6
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      usb_error_irq_enable <= usb_irq_pkg::reg_reset;
    else if (wr_en && hit(paddr, usb_irq_pkg::error_en_off))
      usb_error_irq_enable <= wbyte & usb_irq_pkg::error_mask; // see R14
  end

  // summary tracks enabled flags only; software writes cannot touch it
  assign error_summary_flag = |(usb_error_flags & usb_error_irq_enable); // see R4 R5 R19

  // status flags: software may clear or set (debug), except the summary bit
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      status_flag_reg <= usb_irq_pkg::reg_reset;
    else
    begin
      if (wr_en && hit(paddr, usb_irq_pkg::status_flag_off))
        status_flag_reg <= (wbyte & usb_irq_pkg::status_sw_mask) | status_set; // see R20
      else
        status_flag_reg <= (status_flag_reg | status_set) & usb_irq_pkg::status_sw_mask;
      status_flag_reg[usb_irq_pkg::error_summary_bit] <= error_summary_flag; // see R19
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      usb_status_irq_enable <= usb_irq_pkg::reg_reset;
    else if (wr_en && hit(paddr, usb_irq_pkg::status_en_off))
      usb_status_irq_enable <= wbyte & usb_irq_pkg::status_mask; // see R3
  end

  // firmware is expected to hold module and pull-up off until attach is seen
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      control_reg <= 3'b000;
    else if (wr_en && hit(paddr, usb_irq_pkg::control_off))
      control_reg <= wbyte[2:0]; // see R17
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      module_en <= 1'b0;
      suspended <= 1'b0;
      pullup_en <= 1'b0;
    end
    else
    begin
      module_en <= control_reg[usb_irq_pkg::module_en_bit];
      suspended <= control_reg[usb_irq_pkg::suspend_bit];
      // suspend does not release the pull-up
      pullup_en <= control_reg[usb_irq_pkg::pullup_en_bit]; // see R16
    end
  end

  // request one cycle after the flag/enable pair, from a flop
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      usb_request_flag <= 1'b0;
    else
      usb_request_flag <= |(status_flag_reg & usb_status_irq_enable); // see R1 R18
  end

  // apb: one wait state so read data comes from a flop
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pslverr <= !mapped(paddr);
      case (paddr)
        usb_irq_pkg::status_flag_off: prdata <= {24'h000000, status_flag_reg};
        usb_irq_pkg::status_en_off: prdata <= {24'h000000, usb_status_irq_enable};
        usb_irq_pkg::error_flag_off: prdata <= {24'h000000, usb_error_flags};
        usb_irq_pkg::error_en_off: prdata <= {24'h000000, usb_error_irq_enable};
        usb_irq_pkg::control_off: prdata <= {29'h00000000, control_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  property p_request_follows;
    @(posedge core_clk) disable iff (!rst_b)
    |(status_flag_reg & usb_status_irq_enable) |=> usb_request_flag;
  endproperty
  a_request_follows: assert property (p_request_follows) else $error("request missing"); // see R1

  property p_request_masked;
    @(posedge core_clk) disable iff (!rst_b)
    (status_flag_reg & usb_status_irq_enable) == 8'h00 |=> !usb_request_flag;
  endproperty
  a_request_masked: assert property (p_request_masked) else $error("masked request"); // see R18

  property p_err_set;
    @(posedge core_clk) disable iff (!rst_b)
    error_event.stuff_error |=> usb_error_flags[usb_irq_pkg::stuff_error_bit];
  endproperty
  a_err_set: assert property (p_err_set) else $error("stuff flag not set"); // see R6

  property p_err_sticky;
    @(posedge core_clk) disable iff (!rst_b)
    usb_error_flags[usb_irq_pkg::packet_id_fail_bit]
      && !(wr_en && hit(paddr, usb_irq_pkg::error_flag_off))
      |=> usb_error_flags[usb_irq_pkg::packet_id_fail_bit];
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("flag dropped"); // see R7

  property p_err_zero;
    @(posedge core_clk) disable iff (!rst_b)
    usb_error_flags[6:5] == 2'b00 && usb_status_irq_enable[7] == 1'b0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("reserved bit set"); // see R8

  property p_summary;
    @(posedge core_clk) disable iff (!rst_b)
    ##1 status_flag_reg[usb_irq_pkg::error_summary_bit]
      == $past(|(usb_error_flags & usb_error_irq_enable));
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch"); // see R4

  property p_set_wins;
    @(posedge core_clk) disable iff (!rst_b)
    error_event.packet_id_fail && wr_en && hit(paddr, usb_irq_pkg::error_flag_off)
      |=> usb_error_flags[usb_irq_pkg::packet_id_fail_bit];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost"); // see R20

  property p_idle_flag;
    @(posedge core_clk) disable iff (!rst_b)
    idle_timeout |=> status_flag_reg[usb_irq_pkg::idle_detect_bit];
  endproperty
  a_idle_flag: assert property (p_idle_flag) else $error("idle flag missing"); // see R15

  property p_pullup_suspend;
    @(posedge core_clk) disable iff (!rst_b)
    control_reg[usb_irq_pkg::pullup_en_bit] && $rose(suspended) |-> pullup_en;
  endproperty
  a_pullup_suspend: assert property (p_pullup_suspend) else $error("pullup released"); // see R16

  property p_status_set;
    @(posedge core_clk) disable iff (!rst_b)
    status_event.bus_reset |=> status_flag_reg[usb_irq_pkg::bus_reset_bit];
  endproperty
  a_status_set: assert property (p_status_set) else $error("status flag not set"); // see R2

  property p_status_sticky;
    @(posedge core_clk) disable iff (!rst_b)
    status_flag_reg[usb_irq_pkg::frame_start_bit]
      && !(wr_en && hit(paddr, usb_irq_pkg::status_flag_off))
      |=> status_flag_reg[usb_irq_pkg::frame_start_bit];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("flag lost"); // see R2

  property p_summary_write;
    @(posedge core_clk) disable iff (!rst_b)
    wr_en && hit(paddr, usb_irq_pkg::status_flag_off)
      |=> status_flag_reg[usb_irq_pkg::error_summary_bit] == $past(error_summary_flag);
  endproperty
  a_summary_write: assert property (p_summary_write) else $error("summary hit"); // see R19

  property p_flag_clear;
    @(posedge core_clk) disable iff (!rst_b)
    wr_en && hit(paddr, usb_irq_pkg::error_flag_off)
      && !wbyte[usb_irq_pkg::packet_id_fail_bit] && !error_set[usb_irq_pkg::packet_id_fail_bit]
      |=> !usb_error_flags[usb_irq_pkg::packet_id_fail_bit];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // see R7

  property p_turn_flag;
    @(posedge core_clk) disable iff (!rst_b)
    turnaround_timeout |=> usb_error_flags[usb_irq_pkg::turnaround_timeout_bit];
  endproperty
  a_turn_flag: assert property (p_turn_flag) else $error("turnaround flag missing"); // see R9

  property p_en_reserved;
    @(posedge core_clk) disable iff (!rst_b)
    usb_error_irq_enable[6:5] == 2'b00;
  endproperty
  a_en_reserved: assert property (p_en_reserved) else $error("reserved enable set"); // see R14

  property p_err_pass;
    @(posedge core_clk) disable iff (!rst_b)
    usb_error_flags[usb_irq_pkg::stuff_error_bit]
      && usb_error_irq_enable[usb_irq_pkg::stuff_error_bit]
      |=> status_flag_reg[usb_irq_pkg::error_summary_bit];
  endproperty
  a_err_pass: assert property (p_err_pass) else $error("enabled error blocked"); // see R5

  property p_pullup_follows;
    @(posedge core_clk) disable iff (!rst_b)
    1'b1 |=> pullup_en == $past(control_reg[usb_irq_pkg::pullup_en_bit]);
  endproperty
  a_pullup_follows: assert property (p_pullup_follows) else $error("pullup lost"); // see R16

  c_request: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(usb_request_flag));
  c_summary: cover property (@(posedge core_clk) disable iff (!rst_b)
    $rose(status_flag_reg[usb_irq_pkg::error_summary_bit]));
  c_turn: cover property (@(posedge core_clk) disable iff (!rst_b) turnaround_timeout);
  c_idle: cover property (@(posedge core_clk) disable iff (!rst_b) idle_timeout);

endmodule : usb_irq_gate

/* File: sim/usb_line_model.sv */
// far-side model of the serial engine: event pulses, end of packet, bus idle level
// assumes its tasks are called just after a rising core_clk edge
`timescale 1ns/1ns
module usb_line_model (
  input wire logic core_clk,
  output usb_irq_pkg::status_event_t status_event,
  output usb_irq_pkg::error_event_t error_event,
  output logic line_idle_pin,
  output logic eop_seen
);
  // line starts busy so the idle timer stays quiet until a scenario wants it
  initial
  begin
    status_event = '0;
    error_event = '0;
    line_idle_pin = 1'b0;
    eop_seen = 1'b0;
  end

  // events last n cycles; n above one is only used to meet a software clear
  task automatic pulse(input logic [4:0] s, input logic [5:0] e, input logic p, input int n);
    status_event <= s;
    error_event <= e;
    eop_seen <= p;
    repeat (n) @(posedge core_clk);
    status_event <= '0;
    error_event <= '0;
    eop_seen <= 1'b0;
  endtask : pulse

  task automatic set_idle(input logic v);
    line_idle_pin <= v;
  endtask : set_idle
endmodule : usb_line_model

/* File: sim/usb_irq_gate_tb.sv */
// self-checking bench for the usb interrupt gating block
// assumes the apb slave and event timing described by the designer's hand-over
`timescale 1ns/1ns
module usb_irq_gate_tb;
  localparam int sim_idle = 50;
  localparam logic [11:0] a_sts = usb_irq_pkg::status_flag_off;
  localparam logic [11:0] a_sen = usb_irq_pkg::status_en_off;
  localparam logic [11:0] a_err = usb_irq_pkg::error_flag_off;
  localparam logic [11:0] a_een = usb_irq_pkg::error_en_off;
  localparam logic [11:0] a_ctl = usb_irq_pkg::control_off;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, usb_request_flag, pullup_en, module_en, suspended;
  usb_irq_pkg::status_event_t status_event;
  usb_irq_pkg::error_event_t error_event;
  logic line_idle_pin, eop_seen;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rng = 32'h77595ae8;
  logic [31:0] m;
  logic [33:0] note;
  logic [33:0] notes[$];
  int sbit[5] = '{0, 2, 3, 5, 6};
  int ebit[6] = '{0, 1, 2, 3, 4, 7};

  always #5 core_clk = ~core_clk;

  usb_irq_gate #(.idle_cycles(sim_idle)) usb_irq_gate_inst (.core_clk, .rst_b, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .status_event, .error_event,
    .line_idle_pin, .eop_seen, .usb_request_flag, .pullup_en, .module_en, .suspended);
  usb_line_model usb_line_model_inst (.core_clk, .status_event, .error_event, .line_idle_pin,
    .eop_seen);

  task automatic cmp_bus(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp_bus

  task automatic cmp_pin(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : cmp_pin

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // one note per transfer: {error expected, is read, read data}
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] exp, input logic err = 1'b0);
    notes.push_back({err, ~wr, exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, exp);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : settle

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  always @(posedge core_clk)
  begin
    if (rst_b === 1'b1 && pready === 1'b1)
    begin
      note = notes.pop_front();
      cmp_pin("pslverr", note[33], pslverr);
      if (note[32])
        cmp_bus("prdata", note[31:0], prdata);
    end
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(a_sts, 32'h0);
    rd(a_sen, 32'h0);
    rd(a_err, 32'h0);
    rd(a_een, 32'h0);
    apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
    wr(a_sts, 32'h2);
    rd(a_sts, 32'h0);
    rng = xs(rng);
    wr(a_sen, rng);
    rd(a_sen, rng & 32'h7f);
    rng = xs(rng);
    wr(a_een, rng);
    rd(a_een, rng & 32'h9f);
    // a write with byte lane 0 off must leave the register alone
    pstrb <= 4'h0;
    wr(a_een, ~rng);
    pstrb <= 4'hf;
    rd(a_een, rng & 32'h9f);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      m = 32'h1 << sbit[i];
      wr(a_sen, ~m & 32'h7f);
      usb_line_model_inst.pulse(5'h1 << i, 6'h0, 1'b0, 1);
      settle(2);
      rd(a_sts, m);
      cmp_pin("masked request", 1'b0, usb_request_flag);
      wr(a_sen, m);
      settle(2);
      cmp_pin("enabled request", 1'b1, usb_request_flag);
      wr(a_sts, 32'h0);
      settle(2);
      cmp_pin("cleared request", 1'b0, usb_request_flag);
    end
    $display("test status gating done");
    wr(a_sen, 32'h2);
    for (int i = 0; i < 6; i++)
    begin
      m = 32'h1 << ebit[i];
      wr(a_een, 32'h0);
      usb_line_model_inst.pulse(5'h0, 6'h1 << i, 1'b0, 1);
      settle(2);
      rd(a_err, m);
      rd(a_sts, 32'h0);
      wr(a_een, m);
      settle(2);
      rd(a_sts, 32'h2);
      cmp_pin("error request", 1'b1, usb_request_flag);
      wr(a_err, 32'hff);
      wr(a_sts, 32'h0);
      rd(a_err, m);
      rd(a_sts, 32'h2);
      wr(a_err, 32'h0);
      settle(3);
      rd(a_sts, 32'h0);
    end
    $display("test error gating done");
    wr(a_een, 32'h0);
    // the event is held over the edge at which the clearing write lands
    fork
      wr(a_err, 32'h0);
      begin
        @(posedge core_clk);
        usb_line_model_inst.pulse(5'h0, 6'h1, 1'b0, 2);
      end
    join
    rd(a_err, 32'h1);
    wr(a_err, 32'h0);
    $display("test set over clear done");
    wr(a_ctl, 32'h7);
    rd(a_ctl, 32'h7);
    cmp_pin("module enable", 1'b1, module_en);
    cmp_pin("suspended", 1'b1, suspended);
    usb_line_model_inst.set_idle(1'b1);
    // end of packet only after the synchronised line shows idle, else the watch disarms
    settle(5);
    usb_line_model_inst.pulse(5'h0, 6'h0, 1'b1, 1);
    settle(20);
    rd(a_sts, 32'h0);
    rd(a_err, 32'h0);
    settle(40);
    rd(a_sts, 32'h10);
    rd(a_err, 32'h0);
    settle(80);
    rd(a_err, 32'h10);
    cmp_pin("pull-up while suspended", 1'b1, pullup_en);
    $display("test idle and suspend done");
    end_sim();
  end
endmodule : usb_irq_gate_tb
